/* hdl/asr_adc_report_ctrl.sv */
// ADC sampling and report control, top of the block.
// Assumes an AHB-Lite master and an ADC macro on CLK_SYS; the macro
// answers ADC_START with a one-cycle ADC_DONE and a 12-bit result.
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module asr_adc_report_ctrl #(
  parameter int          CLK_KHZ_P = asr_pkg::CLK_KHZ,
  // Calibration words; the values below are arbitrary.
  parameter logic [15:0] REF_CAL   = 16'h05f0,
  parameter logic [15:0] HEAT_LOW  = 16'h0400,
  parameter logic [15:0] HEAT_HIGH = 16'h0500
)(
  // Clock and reset
  input  wire logic                         CLK_SYS,
  input  wire logic                         RESET_N,
  // AHB-Lite slave
  input  wire logic                         HSEL,
  input  wire logic [31:0]                  HADDR,
  input  wire logic [1:0]                   HTRANS,
  input  wire logic                         HWRITE,
  input  wire logic [2:0]                   HSIZE,
  input  wire logic [asr_pkg::BUS_W-1:0]    HWDATA,
  input  wire logic                         HREADY,
  output var  logic [asr_pkg::BUS_W-1:0]    HRDATA,
  output var  logic                         HREADYOUT,
  output var  logic                         HRESP,
  // ADC macro
  output var  logic                         ADC_START,
  output var  logic [2:0]                   ADC_CHANNEL,
  input  wire logic                         ADC_DONE,
  input  wire logic [asr_pkg::SAMPLE_W-1:0] ADC_RESULT,
  // Report endpoint
  output var  logic                         REPORT_VALID,
  output var  logic [7:0]                   REPORT_DATA,
  output var  logic                         REPORT_LAST,
  input  wire logic                         REPORT_READY
);
  import asr_pkg::*;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);

  asr_state_t  state;
  logic        ap_wr;
  logic [7:0]  ap_addr;
  logic        take;
  logic        wr_ctrl;
  logic        wr_cmd;
  logic        wr_stat;
  logic        ctrl_ok;
  logic        ctrl_apply;
  logic [4:0]  w_khz;
  logic        cfg_en;
  logic [7:0]  cfg_chan;
  logic [7:0]  cfg_mode;
  logic [7:0]  cfg_rate;
  logic        cont_on;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  logic        rej;
  logic        ovr;
  logic        cmd_pend;
  logic [7:0]  cmd_byte;
  logic        go_set;
  logic        go_cal;
  logic        go_inp;
  logic        last_set;
  logic        fin;
  logic        hand;
  logic        job_cont;
  logic        job_down;
  logic [2:0]  cur_ch;
  logic [2:0]  left;
  logic [2:0]  n_ch;
  logic [5:0]  wr_ptr;
  logic [4:0]  sets;
  logic [7:0]  seq;
  logic        fbank;
  logic        sbank;
  logic [5:0]  blen [2];
  logic [7:0]  mem [2*REPORT_LEN];
  logic [15:0] cal_w [CAL_WORDS];
  logic [15:0] rate_per;
  logic        rate_tick;
  logic        space_tick;
  logic        space_ok;
  logic        snd_busy;
  logic [5:0]  rd_idx;
  logic [7:0]  rd_byte;
  logic [7:0]  res_lo;
  logic [6:0]  gap;

  // ==========================================================
  // Bus slave: zero wait states, always OKAY
  assign take    = HSEL && HTRANS[1] && HREADY;
  assign wr_ctrl = ap_wr && (ap_addr == OFS_CONTROL);
  assign wr_cmd  = ap_wr && (ap_addr == OFS_COMMAND);
  assign wr_stat = ap_wr && (ap_addr == OFS_STATUS);

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      ap_wr   <= 1'b0;
      ap_addr <= '0;
    end
    else if (HREADY)
    begin
      ap_wr   <= take && HWRITE;
      ap_addr <= {HADDR[7:2], 2'b00};
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    HREADYOUT <= 1'b1;
    HRESP     <= 1'b0;
    if (!RESET_N)
      HRDATA <= '0;
    else if (take && !HWRITE)
    begin
      case ({HADDR[7:2], 2'b00})
        OFS_CONTROL: HRDATA <= ctrl_word;
        OFS_STATUS:  HRDATA <= stat_word;
        default:     HRDATA <= '0;
      endcase
    end
  end

  assign ctrl_word = {cfg_rate, cfg_mode, cfg_chan, 7'h00, cfg_en};
  assign stat_word = {16'h0000, seq, 4'h0, ovr, rej, snd_busy, cfg_en};

  // ==========================================================
  // Configuration
  assign w_khz   = rate_khz(HWDATA[RATE_LSB +: 8]);
  assign ctrl_ok = (HWDATA[EN_LSB +: 8] <= EN_ON)
    && chan_ok(HWDATA[CHAN_LSB +: 8])
    && (HWDATA[MODE_LSB +: 8] <= MODE_CONT)
    && (w_khz != 5'h00)
    && (w_khz <= limit_khz(HWDATA[CHAN_LSB +: 8]));
  assign ctrl_apply = wr_ctrl && ctrl_ok;
  assign cont_on    = cfg_en && (cfg_mode == MODE_CONT);

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      cfg_en   <= CONTROL_RST[EN_LSB];
      cfg_chan <= CONTROL_RST[CHAN_LSB +: 8];
      cfg_mode <= CONTROL_RST[MODE_LSB +: 8];
      cfg_rate <= CONTROL_RST[RATE_LSB +: 8];
    end
    else if (ctrl_apply)
    begin
      cfg_en   <= (HWDATA[EN_LSB +: 8] == EN_ON);
      cfg_chan <= HWDATA[CHAN_LSB +: 8];
      cfg_mode <= HWDATA[MODE_LSB +: 8];
      cfg_rate <= HWDATA[RATE_LSB +: 8];
    end
  end

  // Sticky flags: a new event beats a clear in the same cycle.
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      rej <= 1'b0;
      ovr <= 1'b0;
    end
    else
    begin
      rej <= (rej && !(wr_stat && HWDATA[ST_REJ])) ||
             (wr_ctrl && !ctrl_ok);
      ovr <= (ovr && !(wr_stat && HWDATA[ST_OVR])) || (fin && snd_busy);
    end
  end

  // Commands written during continuous mode never become pending.
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      cmd_pend <= 1'b0;
      cmd_byte <= '0;
    end
    else
    begin
      cmd_pend <= (cmd_pend && (state != S_IDLE)) ||
                  (wr_cmd && !cont_on);
      if (wr_cmd)
        cmd_byte <= HWDATA[7:0];
    end
  end

  // ==========================================================
  // Pacing
  assign rate_per = 16'((CLK_KHZ_P + int'(rate_khz(cfg_rate)) - 1) /
                        int'(rate_khz(cfg_rate)));

  asr_tick_timer #(.W(16)) u_rate (
    .clk     (CLK_SYS),
    .rst_n   (RESET_N),
    .restart (!cont_on || ctrl_apply),
    .period  (rate_per),
    .tick    (rate_tick)
  );

  asr_tick_timer #(.W(16)) u_space (
    .clk     (CLK_SYS),
    .rst_n   (RESET_N),
    .restart (ADC_START),
    .period  (16'(SPACE_CYC)),
    .tick    (space_tick)
  );

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N || space_tick)
      space_ok <= 1'b1;
    else if (ADC_START)
      space_ok <= 1'b0;
  end

  // ==========================================================
  // Conversion sequencer
  assign n_ch     = (cfg_chan == 8'h00) ? 3'h1 : cfg_chan[2:0];
  assign go_set   = (state == S_IDLE) && cont_on && rate_tick;
  assign go_cal   = (state == S_IDLE) && !cont_on && cmd_pend && cfg_en
                    && (cmd_byte == CMD_CAL);
  assign go_inp   = (state == S_IDLE) && !cont_on && cmd_pend && cfg_en
                    && (cmd_byte == CMD_INPUTS)
                    && (cfg_chan != 8'h00);
  assign last_set = (5'(sets + 1'b1) == sets_max(cfg_chan));
  assign fin      = (state == S_NEXT) && (left == 3'h0) &&
                    (!job_cont || last_set);
  assign hand     = fin && !snd_busy;

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N || ctrl_apply)
    begin
      state       <= S_IDLE;
      job_cont    <= 1'b0;
      job_down    <= 1'b0;
      cur_ch      <= '0;
      left        <= '0;
      wr_ptr      <= POS_DATA;
      sets        <= '0;
      ADC_START   <= 1'b0;
      ADC_CHANNEL <= '0;
    end
    else
    begin
      ADC_START <= 1'b0;
      unique case (state)
        S_IDLE:
          if (go_set)
          begin
            job_cont <= 1'b1;
            job_down <= 1'b0;
            cur_ch   <= (cfg_chan == 8'h00) ? CH_TEMP : 3'h0;
            left     <= n_ch;
            state    <= S_START;
          end
          else if (go_cal)
          begin
            job_cont <= 1'b0;
            job_down <= 1'b1;
            cur_ch   <= CH_BANDGAP;
            left     <= 3'h2;
            wr_ptr   <= POS_MEAS;
            state    <= S_START;
          end
          else if (go_inp)
          begin
            job_cont <= 1'b0;
            job_down <= 1'b0;
            cur_ch   <= 3'h0;
            left     <= n_ch;
            wr_ptr   <= POS_DATA;
            state    <= S_START;
          end
        S_START:
          if (space_ok)
          begin
            ADC_START   <= 1'b1;
            ADC_CHANNEL <= cur_ch;
            state       <= S_WAIT;
          end
        S_WAIT:
          if (ADC_DONE)
          begin
            wr_ptr <= 6'(wr_ptr + 6'h02);
            left   <= 3'(left - 1'b1);
            cur_ch <= job_down ? 3'(cur_ch - 1'b1) : 3'(cur_ch + 1'b1);
            state  <= S_NEXT;
          end
        S_NEXT:
          if (left != 3'h0)
            state <= S_START;
          else
          begin
            state <= S_IDLE;
            if (job_cont && last_set)
            begin
              sets   <= '0;
              wr_ptr <= POS_DATA;
            end
            else if (job_cont)
              sets <= 5'(sets + 1'b1);
          end
      endcase
    end
  end

  // ==========================================================
  // Report banks: one fills while the other is sent
  assign cal_w[0] = REF_CAL;
  assign cal_w[1] = HEAT_LOW;
  assign cal_w[2] = HEAT_HIGH;
  assign res_lo   = ADC_RESULT[7:0];

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      fbank   <= 1'b0;
      sbank   <= 1'b0;
      seq     <= '0;
      blen[0] <= '0;
      blen[1] <= '0;
    end
    else if (hand)
    begin
      sbank       <= fbank;
      fbank       <= !fbank;
      blen[fbank] <= wr_ptr;
      if (job_cont)
        seq <= 8'(seq + 1'b1);
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if ((state == S_WAIT) && ADC_DONE)
    begin
      mem[{fbank, wr_ptr}]                <= res_lo;
      mem[{fbank, 6'(wr_ptr + 6'h01)}]    <= {4'h0, ADC_RESULT[11:8]};
    end
    if (go_cal || go_inp)
    begin
      mem[{fbank, POS_ID}]   <= ID_SINGLE;
      mem[{fbank, POS_HEAD}] <= cmd_byte;
    end
    if (go_cal)
      for (int k = 0; k < CAL_WORDS; k++)
      begin
        mem[{fbank, 6'(POS_DATA + 2 * k)}]     <= cal_w[k][7:0];
        mem[{fbank, 6'(POS_DATA + 2 * k + 1)}] <= cal_w[k][15:8];
      end
    if (hand && job_cont)
    begin
      mem[{fbank, POS_ID}]   <= ID_DATA;
      mem[{fbank, POS_HEAD}] <= seq;
    end
  end

  // Bytes past the filled length go out as zero padding.
  assign rd_byte = (rd_idx >= blen[sbank]) ? 8'h00 : mem[{sbank, rd_idx}];

  asr_report_sender #(.LEN(REPORT_LEN)) u_send (
    .clk       (CLK_SYS),
    .rst_n     (RESET_N),
    .start     (hand),
    .busy      (snd_busy),
    .rd_idx    (rd_idx),
    .rd_byte   (rd_byte),
    .out_valid (REPORT_VALID),
    .out_data  (REPORT_DATA),
    .out_last  (REPORT_LAST),
    .out_ready (REPORT_READY)
  );

  // ==========================================================
  // Checks
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N || ADC_START)
      gap <= '0;
    else if (gap != 7'h7f)
      gap <= 7'(gap + 1'b1);
  end

  sequence s_cont_idle;
    (state == S_IDLE) && cont_on;
  endsequence
  property p_ss_ignored;
    s_cont_idle |=> (state == S_IDLE) || job_cont;
  endproperty
  a_ss_ignored: assert property (p_ss_ignored)
    else $error("single-shot job started in continuous mode");

  property p_cfg_hold;
    wr_ctrl && !ctrl_ok |=> $stable(ctrl_word);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("rejected control write changed the setup");

  property p_seq_step;
    hand && job_cont |=> seq == 8'($past(seq) + 1'b1);
  endproperty
  a_seq_step: assert property (p_seq_step)
    else $error("sequence number did not step by one");

  property p_lsb_first;
    (state == S_WAIT) && ADC_DONE |=>
      mem[{$past(fbank), $past(wr_ptr)}] == $past(res_lo);
  endproperty
  a_lsb_first: assert property (p_lsb_first)
    else $error("low byte of sample not stored first");

  property p_spacing;
    ADC_START |-> gap >= 7'(SPACE_CYC);
  endproperty
  a_spacing: assert property (p_spacing)
    else $error("conversions closer than the channel spacing");

  property p_no_reply;
    (state == S_IDLE) && cmd_pend && !wr_cmd && !cont_on &&
    (cfg_chan == 8'h00) && (cmd_byte == CMD_INPUTS)
      |=> (state == S_IDLE) && !cmd_pend;
  endproperty
  a_no_reply: assert property (p_no_reply)
    else $error("input command answered with no input selected");

  property p_chan_range;
    ADC_START && job_cont |->
      ((cfg_chan == 8'h00) ? (ADC_CHANNEL == CH_TEMP)
                           : (ADC_CHANNEL < cfg_chan[2:0]));
  endproperty
  a_chan_range: assert property (p_chan_range)
    else $error("converted channel outside the selection");

  property p_report_len;
    hand && job_cont |->
      wr_ptr == 6'(POS_DATA + 2 * sets_max(cfg_chan) * n_ch);
  endproperty
  a_report_len: assert property (p_report_len)
    else $error("data report closed with wrong sample count");

endmodule : asr_adc_report_ctrl
`default_nettype wire

/* hdl/asr_pkg.sv */
// Constants, types and lookup functions of the ADC report controller.
// Assumes one 50 MHz system clock and a 32-bit AHB-Lite register bus.
package asr_pkg;

  // ==========================================================
  // Timing
  localparam int          CLK_KHZ     = 50000;
  localparam int          SPACE_NS    = 1000;
  localparam int          SPACE_CYC   =
    (SPACE_NS * (CLK_KHZ / 1000) + 999) / 1000;

  // ==========================================================
  // Widths and register map
  localparam int          BUS_W       = 32;
  localparam int          SAMPLE_W    = 12;
  localparam int          REPORT_LEN  = 64;
  localparam logic [7:0]  OFS_CONTROL = 8'h00;
  localparam logic [7:0]  OFS_COMMAND = 8'h04;
  localparam logic [7:0]  OFS_STATUS  = 8'h08;
  localparam int          EN_LSB      = 0;
  localparam int          CHAN_LSB    = 8;
  localparam int          MODE_LSB    = 16;
  localparam int          RATE_LSB    = 24;
  localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
  localparam int          ST_EN       = 0;
  localparam int          ST_BUSY     = 1;
  localparam int          ST_REJ      = 2;
  localparam int          ST_OVR      = 3;
  localparam int          ST_SEQ_LSB  = 8;

  // ==========================================================
  // Report layout and codes
  localparam logic [7:0]  ID_DATA     = 8'h1d;
  localparam logic [7:0]  ID_SINGLE   = 8'h1e;
  localparam logic [7:0]  EN_ON       = 8'h01;
  localparam logic [7:0]  MODE_CONT   = 8'h01;
  localparam logic [7:0]  CMD_CAL     = 8'h00;
  localparam logic [7:0]  CMD_INPUTS  = 8'h01;
  localparam logic [5:0]  POS_ID      = 6'h00;
  localparam logic [5:0]  POS_HEAD    = 6'h01;
  localparam logic [5:0]  POS_DATA    = 6'h02;
  localparam logic [5:0]  POS_MEAS    = 6'h08;
  localparam int          CAL_WORDS   = 3;
  localparam logic [2:0]  CH_TEMP     = 3'h4;
  localparam logic [2:0]  CH_BANDGAP  = 3'h5;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_START = 2'b01,
    S_WAIT  = 2'b11,
    S_NEXT  = 2'b10
  } asr_state_t;

  // ==========================================================
  // Lookup functions
  function automatic logic [4:0] rate_khz(input logic [7:0] code);
    case (code)
      8'h00:   rate_khz = 5'h01;
      8'h01:   rate_khz = 5'h02;
      8'h02:   rate_khz = 5'h03;
      8'h03:   rate_khz = 5'h04;
      8'h04:   rate_khz = 5'h06;
      8'h05:   rate_khz = 5'h08;
      8'h06:   rate_khz = 5'h0a;
      8'h07:   rate_khz = 5'h0c;
      8'h08:   rate_khz = 5'h0f;
      8'h09:   rate_khz = 5'h10;
      8'h0a:   rate_khz = 5'h14;
      8'h0b:   rate_khz = 5'h18;
      8'h0d:   rate_khz = 5'h1e;
      default: rate_khz = 5'h00;
    endcase
  endfunction : rate_khz

  function automatic logic [4:0] limit_khz(input logic [7:0] chan);
    if (chan == 8'h04)
      limit_khz = 5'h06;
    else if (chan == 8'h02)
      limit_khz = 5'h0f;
    else
      limit_khz = 5'h1e;
  endfunction : limit_khz

  function automatic logic [4:0] sets_max(input logic [7:0] chan);
    if (chan == 8'h04)
      sets_max = 5'h07;
    else if (chan == 8'h02)
      sets_max = 5'h0f;
    else
      sets_max = 5'h1e;
  endfunction : sets_max

  function automatic logic chan_ok(input logic [7:0] chan);
    chan_ok = (chan == 8'h00) || (chan == 8'h01) ||
              (chan == 8'h02) || (chan == 8'h04);
  endfunction : chan_ok

endpackage : asr_pkg

/* hdl/asr_report_sender.sv */
// Sends one whole report of LEN bytes under valid and ready.
// Assumes rd_byte answers rd_idx in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module asr_report_sender #(
  parameter int LEN = 64
)(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Report source
  input  wire logic       start,
  output var  logic       busy,
  output var  logic [5:0] rd_idx,
  input  wire logic [7:0] rd_byte,
  // Byte stream
  output var  logic       out_valid,
  output var  logic [7:0] out_data,
  output var  logic       out_last,
  input  wire logic       out_ready
);
  logic [6:0] idx;

  assign rd_idx = idx[5:0];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      busy      <= 1'b0;
      idx       <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
      out_last  <= 1'b0;
    end
    else if (start && !busy)
    begin
      busy <= 1'b1;
      idx  <= '0;
    end
    else if (busy && (!out_valid || out_ready))
    begin
      if (idx == 7'(LEN))
      begin
        busy      <= 1'b0;
        out_valid <= 1'b0;
        out_last  <= 1'b0;
      end
      else
      begin
        out_valid <= 1'b1;
        out_data  <= rd_byte;
        out_last  <= (idx == 7'(LEN - 1));
        idx       <= 7'(idx + 1'b1);
      end
    end
  end

  // A byte on offer stays until the endpoint takes it.
  property p_hold;
    @(posedge clk) disable iff (!rst_n)
    out_valid && !out_ready |=>
      out_valid && $stable(out_data) && $stable(out_last);
  endproperty
  a_hold: assert property (p_hold)
    else $error("report byte changed before it was taken");

endmodule : asr_report_sender
`default_nettype wire

/* hdl/asr_tick_timer.sv */
// Free running period timer giving a one-cycle tick.
// Assumes period is at least one and restart comes from CLK_SYS logic.
`timescale 1ns/1ps
`default_nettype none
module asr_tick_timer #(
  parameter int W = 16
)(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Control
  input  wire logic         restart,
  input  wire logic [W-1:0] period,
  // Output
  output var  logic         tick
);
  logic [W-1:0] cnt;

  always_ff @(posedge clk)
  begin
    if (!rst_n || restart)
    begin
      cnt  <= '0;
      tick <= 1'b0;
    end
    else if (cnt >= W'(period - 1'b1))
    begin
      cnt  <= '0;
      tick <= 1'b1;
    end
    else
    begin
      cnt  <= W'(cnt + 1'b1);
      tick <= 1'b0;
    end
  end

endmodule : asr_tick_timer
`default_nettype wire

/* sim/asr_adc_model.sv */
// ADC macro model: answers each start after a short or a long delay.
// Assumes starts come from the controller on the same clock.
`timescale 1ns/1ps
`default_nettype none
module asr_adc_model (
  // Clock
  input  wire logic        clk,
  // Conversion handshake
  input  wire logic        start,
  input  wire logic [2:0]  channel,
  output var  logic        done,
  output var  logic [11:0] result
);
  logic [3:0] wait_cnt = 4'h0;
  logic       slow     = 1'b0;
  logic [2:0] ch       = 3'h0;
  initial
  begin
    done   = 1'b0;
    result = 12'h000;
  end
  // The result bus changes every cycle outside a done pulse.
  always @(posedge clk)
  begin
    done   <= 1'b0;
    result <= ~result;
    if (start)
    begin
      ch       <= channel;
      wait_cnt <= slow ? 4'h9 : 4'h1;
      slow     <= ~slow;
    end
    else if (wait_cnt != 4'h0)
    begin
      wait_cnt <= wait_cnt - 4'h1;
      if (wait_cnt == 4'h1)
      begin
        done   <= 1'b1;
        result <= {1'b1, ch, 8'h3c};
      end
    end
  end
endmodule : asr_adc_model
`default_nettype wire

/* sim/asr_adc_report_ctrl_bench.sv */
// Testbench of the ADC report controller over AHB-Lite.
// Assumes the ADC model in asr_adc_model.sv.
`timescale 1ns/1ps
`default_nettype none
module asr_adc_report_ctrl_bench;
  import asr_pkg::*;
  localparam logic [15:0] CAL [3] = '{16'h1234, 16'h0456, 16'h0789};
  localparam logic [32:0] ROWS [6] = '{
    33'h0_0000_0101, 33'h1_0000_0301, 33'h1_0d00_0401,
    33'h0_0400_0401, 33'h1_0900_0201, 33'h0_0d00_0001};
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'b00;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata, r, cfg;
  logic        hreadyout, hresp, adc_start, adc_done, rep_valid, rep_last;
  logic [2:0]  adc_channel;
  logic [11:0] adc_result;
  logic [7:0]  rep_data, seq;
  logic        rep_ready = 1'b0;
  logic [7:0]  rep [64];
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          gap = 1000;
  always #10 clk_sys = ~clk_sys;
  asr_adc_report_ctrl #(.CLK_KHZ_P(600), .REF_CAL(CAL[0]),
    .HEAT_LOW(CAL[1]), .HEAT_HIGH(CAL[2])) i_asr_adc_report_ctrl (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .HSEL(1'b1), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .ADC_START(adc_start), .ADC_CHANNEL(adc_channel),
    .ADC_DONE(adc_done), .ADC_RESULT(adc_result), .REPORT_VALID(rep_valid),
    .REPORT_DATA(rep_data), .REPORT_LAST(rep_last), .REPORT_READY(rep_ready));
  asr_adc_model i_asr_adc_model (.clk(clk_sys), .start(adc_start),
    .channel(adc_channel), .done(adc_done), .result(adc_result));

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t ns: expected %h, got %h", $time, exp, got);
    end
  endtask : check

  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      n_mismatch++;
      summarize();
    end
  endtask : wait_ready

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    r = hrdata;
    check(32'h0, {31'h0, hresp});
  endtask : ahb

  // Takes one report while stalling the stream every other cycle.
  task automatic get_report;
    int n;
    int i;
    n = 0;
    i = 0;
    while (i < 64 && n < 6000)
    begin
      @(posedge clk_sys);
      n++;
      if (rep_valid === 1'b1 && rep_ready === 1'b1)
      begin
        rep[i] = rep_data;
        if (i == 63) check(32'h1, {31'h0, rep_last});
        i++;
      end
      rep_ready <= ~rep_ready;
    end
    if (i < 64)
    begin
      n_mismatch++;
      summarize();
    end
  endtask : get_report

  task automatic word(input int i, input logic [15:0] exp);
    check({16'h0, exp}, {16'h0, rep[i+1], rep[i]});
  endtask : word

  always @(posedge clk_sys)
  begin
    gap <= adc_start ? 0 : gap + 1;
    if (adc_start === 1'b1) check(32'h1, {31'h0, gap >= 52});
  end

  initial
  begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    ahb(1'b0, OFS_STATUS, 32'h0);
    check(32'h0, r);
    cfg = CONTROL_RST;
    for (int k = 0; k < 20; k++)
    begin
      if (k < 14)
      begin
        ahb(1'b1, OFS_CONTROL, {k[7:0], 24'h000101});
        ahb(1'b0, OFS_STATUS, 32'h0);
        check({31'h0, k == 12}, {31'h0, r[ST_REJ]});
      end
      else
      begin
        ahb(1'b1, OFS_CONTROL, ROWS[k-14][31:0]);
        ahb(1'b0, OFS_STATUS, 32'h0);
        check({31'h0, ROWS[k-14][32]}, {31'h0, r[ST_REJ]});
        if (!ROWS[k-14][32]) cfg = ROWS[k-14][31:0];
        ahb(1'b0, OFS_CONTROL, 32'h0);
        check(cfg, r);
      end
      ahb(1'b1, OFS_STATUS, 32'h4);
    end
    ahb(1'b0, 8'h40, 32'h0);
    check(32'h0, r);
    ahb(1'b1, OFS_CONTROL, 32'h0000_0201);
    ahb(1'b1, OFS_COMMAND, 32'h1);
    get_report();
    check({24'h0, ID_SINGLE, 8'h01}, {16'h0, rep[0], rep[1]});
    word(2, 16'h083c);
    word(4, 16'h093c);
    word(6, 16'h0);
    word(8, 16'h0);
    ahb(1'b1, OFS_COMMAND, 32'h0);
    get_report();
    check({24'h0, ID_SINGLE, 8'h00}, {16'h0, rep[0], rep[1]});
    for (int k = 0; k < 3; k++) word(2 + 2 * k, CAL[k]);
    word(8, 16'h0d3c);
    word(10, 16'h0c3c);
    ahb(1'b1, OFS_CONTROL, 32'h0000_0001);
    ahb(1'b1, OFS_COMMAND, 32'h1);
    repeat (300)
    begin
      @(posedge clk_sys);
      if (rep_valid !== 1'b0) check(32'h0, {31'h0, rep_valid});
    end
    ahb(1'b1, OFS_CONTROL, 32'h0d01_0101);
    get_report();
    seq = rep[1];
    check({24'h0, ID_DATA}, {24'h0, rep[0]});
    word(2, 16'h083c);
    word(60, 16'h083c);
    word(62, 16'h0);
    ahb(1'b1, OFS_COMMAND, 32'h1);
    get_report();
    check({24'h0, ID_DATA}, {24'h0, rep[0]});
    check({24'h0, seq + 8'h01}, {24'h0, rep[1]});
    ahb(1'b0, OFS_STATUS, 32'h0);
    check({16'h0, seq + 8'h02, 8'h01}, r);
    rep_ready <= 1'b0;
    repeat (4000) @(posedge clk_sys);
    ahb(1'b0, OFS_STATUS, 32'h0);
    check(32'h1, {31'h0, r[ST_OVR]});
    check({24'h0, seq + 8'h03}, {24'h0, r[15:8]});
    ahb(1'b1, OFS_STATUS, 32'h8);
    ahb(1'b0, OFS_STATUS, 32'h0);
    check(32'h0, {31'h0, r[ST_OVR]});
    ahb(1'b1, OFS_CONTROL, 32'h0);
    summarize();
  end
endmodule : asr_adc_report_ctrl_bench
`default_nettype wire
